//--- design/igcfl_pkg.sv
// Shared constants and helpers for the inverter gate command controller
package igcfl_pkg;

  // Timing figures in their own units
  localparam int CLK_PERIOD_NS   = 40;
  localparam int CLK_HZ          = 25000000;
  localparam int DEAD_TIME_NS    = 1500;
  localparam int MIN_PULSE_NS    = 500;
  localparam int CARRIER_MAX_HZ  = 20000;
  localparam int FAULT_RESP_NS   = 20000;
  localparam int EXT_SD_HOLD_NS  = 6000;

  // Derived cycle counts: least times round up, longest times round down
  localparam int DEAD_CYC        = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PULSE_CYC   = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CARRIER_MIN_CYC = (CLK_HZ + CARRIER_MAX_HZ - 1) / CARRIER_MAX_HZ;
  localparam int FAULT_RESP_CYC  = FAULT_RESP_NS / CLK_PERIOD_NS;
  localparam int EXT_SD_HOLD_CYC = (EXT_SD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Carrier counter and duty width
  localparam int CNT_W           = 11;

  // Reset values
  localparam logic          FLINE_RST = 1'b1;
  localparam logic [2:0]    CMD_RST   = 3'h0;

  // Controller states, Gray coded along idle -> run -> stop
  typedef enum logic [1:0] {
    IGCFL_IDLE = 2'h0,
    IGCFL_RUN  = 2'h1,
    IGCFL_STOP = 2'h3
  } igcfl_state_t;

  // Keep duty inside the window where every pulse meets the least width
  function automatic logic [CNT_W-1:0] duty_clamp(input logic [CNT_W-1:0] d,
                                                  input logic [CNT_W-1:0] period);
    logic [CNT_W-1:0] lo_lim;
    logic [CNT_W-1:0] hi_lim;
    lo_lim = CNT_W'(DEAD_CYC + MIN_PULSE_CYC);
    hi_lim = period - CNT_W'(DEAD_CYC + MIN_PULSE_CYC);
    if (d < lo_lim)
      duty_clamp = lo_lim;
    else if (d > hi_lim)
      duty_clamp = hi_lim;
    else
      duty_clamp = d;
  endfunction : duty_clamp

endpackage : igcfl_pkg

//--- design/igcfl_phase_if.sv
// Carrier, duty and command signals between controller and one phase generator
`timescale 1ns/10ps
interface igcfl_phase_if;
  import igcfl_pkg::*;
  logic [CNT_W-1:0] carrier;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] duty;
  logic             run;
  logic             hi;
  logic             lo;

  modport gen (input carrier, input period, input duty, input run, output hi, output lo);
  modport ctl (output carrier, output period, output duty, output run, input hi, input lo);
endinterface : igcfl_phase_if

//--- design/igcfl_phase_gen.sv
// Complementary command pair of one phase with dead time and pulse width limits
`timescale 1ns/10ps
module igcfl_phase_gen (
  input  wire logic     clk_i,
  input  wire logic     sys_rst_i,
  igcfl_phase_if.gen    ph
);
  import igcfl_pkg::*;

  logic             active_reg;
  logic             active_next;
  logic             hi_reg;
  logic             hi_next;
  logic             lo_reg;
  logic             lo_next;
  logic [CNT_W-1:0] d;

  // Start only at a carrier wrap so the first pulses are whole; stop at once
  always_comb
  begin
    d           = duty_clamp(ph.duty, ph.period);
    active_next = ph.run & (active_reg | (ph.carrier == '0));
    // High window starts one dead time after the wrap, low window one after high ends
    hi_next     = active_next & (ph.carrier >= CNT_W'(DEAD_CYC)) & (ph.carrier < d);
    lo_next     = active_next & (ph.carrier >= d + CNT_W'(DEAD_CYC));
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      active_reg <= 1'b0;
      hi_reg     <= 1'b0;
      lo_reg     <= 1'b0;
    end
    else
    begin
      active_reg <= active_next;
      hi_reg     <= hi_next;
      lo_reg     <= lo_next;
    end
  end

  assign ph.hi = hi_reg;
  assign ph.lo = lo_reg;

  // Helper counters: cycles with both off, and length of the current high pulse
  logic [CNT_W-1:0] gap_cnt;
  logic [CNT_W-1:0] hw_cnt;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      gap_cnt <= CNT_W'(DEAD_CYC);
      hw_cnt  <= '0;
    end
    else
    begin
      gap_cnt <= (hi_reg | lo_reg) ? '0 : ((&gap_cnt) ? gap_cnt : gap_cnt + 1'b1);
      hw_cnt  <= hi_reg ? ((&hw_cnt) ? hw_cnt : hw_cnt + 1'b1) : '0;
    end
  end

  a_dead_time_gap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    // The counter already holds every off cycle before the rise
    ($rose(hi_reg) || $rose(lo_reg)) |-> gap_cnt >= CNT_W'(DEAD_CYC))
    else $error("dead time between phase commands too short");

  a_min_high_width: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ph.run)
    $fell(hi_reg) |-> hw_cnt >= CNT_W'(MIN_PULSE_CYC))
    else $error("high command pulse narrower than the least width");

  a_no_overlap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hi_reg |-> !lo_reg ##1 !(lo_reg && $past(hi_reg)))
    else $error("high and low commands overlap");

endmodule : igcfl_phase_gen

//--- design/igcfl_host.sv
// Controller that drives the gate driver command pins and watches its fault line
// Contract
// - Insert at least 1.5 us dead time.
// - Every command pulse at least 0.5 us. The code cuts a pulse short when the run state is left.
// - Carrier frequency at most 20 kHz.
// - Always actively drive command outputs.
// - Current limit tied to shutdown stops highs.
// - Inverted fault line may feed shutdown input.
// - Drop all commands within 20 us.
// - External low shuts low sides, hold 6 us.
// - Fault line open collector, wired low.
// - Monitor fault line, stop all phases.
`timescale 1ns/10ps
module igcfl_host #(
  parameter int PERIOD_CYC = igcfl_pkg::CARRIER_MIN_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        run_i,
  input  wire logic [igcfl_pkg::CNT_W-1:0] duty_u_i,
  input  wire logic [igcfl_pkg::CNT_W-1:0] duty_v_i,
  input  wire logic [igcfl_pkg::CNT_W-1:0] duty_w_i,
  input  wire logic                        clear_i,
  input  wire logic                        ext_shutdown_i,
  input  wire logic                        sd_follow_fault_i,
  input  wire logic                        current_limit_out_i,
  input  wire logic                        fault_wired_line_i,
  output logic                             fault_wired_line_o,
  output logic                             fault_wired_line_oe_o,
  output logic [2:0]                       high_side_cmd_o,
  output logic [2:0]                       low_side_cmd_o,
  output logic                             high_side_shutdown_in_o,
  output logic                             fault_latched_o,
  output logic                             running_o
);
  import igcfl_pkg::*;

  localparam logic [CNT_W-1:0] PERIOD = CNT_W'(PERIOD_CYC);
  localparam logic [CNT_W-1:0] EXT_HOLD = CNT_W'(EXT_SD_HOLD_CYC);

  igcfl_state_t     state_reg;
  igcfl_state_t     state_next;
  logic [CNT_W-1:0] carrier_reg;
  logic [CNT_W-1:0] carrier_next;
  logic [2:0]       fsync_reg;
  logic [2:0]       csync_reg;
  logic             fault_level_reg;
  logic             fault_level_next;
  logic             climit_reg;
  logic             climit_next;
  logic [CNT_W-1:0] hold_reg;
  logic [CNT_W-1:0] hold_next;
  logic             pull_reg;
  logic             pull_next;
  logic             latched_reg;
  logic             latched_next;
  logic [2:0]       hi_cmd_reg;
  logic [2:0]       hi_cmd_next;
  logic [2:0]       lo_cmd_reg;
  logic [2:0]       lo_cmd_next;
  logic             sd_reg;
  logic             sd_next;
  logic             running_reg;
  logic             running_next;

  igcfl_phase_if    ph [3] ();

  // One generator per phase, sharing the carrier
  for (genvar g = 0; g < 3; g++)
  begin : g_phase
    assign ph[g].carrier = carrier_reg;
    assign ph[g].period  = PERIOD;
    assign ph[g].run     = (state_reg == IGCFL_RUN);
    assign ph[g].duty    = (g == 0) ? duty_u_i : ((g == 1) ? duty_v_i : duty_w_i);
    igcfl_phase_gen u_gen (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .ph        (ph[g])
    );
  end

  // Pin synchronisers: only the second and third stages are compared
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      fsync_reg <= {3{FLINE_RST}};
      csync_reg <= 3'h0;
    end
    else
    begin
      fsync_reg <= {fsync_reg[1:0], fault_wired_line_i};
      csync_reg <= {csync_reg[1:0], current_limit_out_i};
    end
  end

  // Next values of control state, pull-down timer and registered pins
  always_comb
  begin
    fault_level_next = (fsync_reg[1] == fsync_reg[2]) ? fsync_reg[2] : fault_level_reg;
    climit_next      = (csync_reg[1] == csync_reg[2]) ? csync_reg[2] : climit_reg;
    // Carrier period is PERIOD_CYC cycles; at the default it sits at the 20 kHz limit
    carrier_next     = (carrier_reg >= PERIOD - 1'b1) ? '0 : carrier_reg + 1'b1;
    // Own pull lasts while requested and at least the shutdown hold time
    pull_next        = ext_shutdown_i | (hold_reg > CNT_W'(1));
    hold_next        = ext_shutdown_i ? EXT_HOLD : ((hold_reg != '0) ? hold_reg - 1'b1 : '0);
    // Set wins over clear for the sticky fault flag
    latched_next     = !fault_level_reg | (latched_reg & !clear_i);
    state_next       = state_reg;
    case (state_reg)
      IGCFL_IDLE:
        if (run_i && fault_level_reg && !latched_reg)
          state_next = IGCFL_RUN;
      IGCFL_RUN:
        if (!fault_level_reg || pull_reg)
          state_next = IGCFL_STOP;
        else if (!run_i)
          state_next = IGCFL_IDLE;
      IGCFL_STOP:
        if (!latched_reg && fault_level_reg && !pull_reg)
          state_next = IGCFL_IDLE;
      default:
        state_next = IGCFL_STOP;
    endcase
    // Commands always driven; forced low the moment the run state is left
    hi_cmd_next = (state_next == IGCFL_RUN) ?
                  {ph[2].hi, ph[1].hi, ph[0].hi} : CMD_RST;
    lo_cmd_next = (state_next == IGCFL_RUN) ?
                  {ph[2].lo, ph[1].lo, ph[0].lo} : CMD_RST;
    // Shutdown follows the current limit and optionally the inverted fault line
    sd_next     = climit_reg | (sd_follow_fault_i & !fault_level_reg);
    // Status pin registered so it never glitches on a state decode
    running_next = (state_next == IGCFL_RUN);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg       <= IGCFL_IDLE;
      carrier_reg     <= '0;
      fault_level_reg <= FLINE_RST;
      climit_reg      <= 1'b0;
      hold_reg        <= '0;
      pull_reg        <= 1'b0;
      latched_reg     <= 1'b0;
      hi_cmd_reg      <= CMD_RST;
      lo_cmd_reg      <= CMD_RST;
      sd_reg          <= 1'b0;
      running_reg     <= 1'b0;
    end
    else
    begin
      state_reg       <= state_next;
      carrier_reg     <= carrier_next;
      fault_level_reg <= fault_level_next;
      climit_reg      <= climit_next;
      hold_reg        <= hold_next;
      pull_reg        <= pull_next;
      latched_reg     <= latched_next;
      hi_cmd_reg      <= hi_cmd_next;
      lo_cmd_reg      <= lo_cmd_next;
      sd_reg          <= sd_next;
      running_reg     <= running_next;
    end
  end

  // Open-drain: only ever drive low, otherwise release to the pull-up
  assign fault_wired_line_o      = 1'b0;
  assign fault_wired_line_oe_o   = pull_reg;
  assign high_side_cmd_o         = hi_cmd_reg;
  assign low_side_cmd_o          = lo_cmd_reg;
  assign high_side_shutdown_in_o = sd_reg;
  assign fault_latched_o         = latched_reg;
  assign running_o               = running_reg;

  // Helper counters for pull length and spacing of high pulses on phase U
  logic [CNT_W-1:0] oe_cnt;
  logic [CNT_W-1:0] rise_cnt;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      oe_cnt   <= '0;
      rise_cnt <= '1;
    end
    else
    begin
      oe_cnt   <= pull_reg ? ((&oe_cnt) ? oe_cnt : oe_cnt + 1'b1) : '0;
      rise_cnt <= $rose(hi_cmd_reg[0]) ? CNT_W'(1) : ((&rise_cnt) ? rise_cnt : rise_cnt + 1'b1);
    end
  end

  a_fault_stops_cmds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !fault_level_reg |-> ##[1:2] (high_side_cmd_o == 3'h0 && low_side_cmd_o == 3'h0))
    else $error("commands not dropped after fault line went low");

  a_no_run_on_fault: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !fault_level_reg |=> state_reg != IGCFL_RUN)
    else $error("controller kept running with fault line low");

  a_ext_pull_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(fault_wired_line_oe_o) |-> oe_cnt >= EXT_HOLD)
    else $error("external shutdown pulse shorter than the hold time");

  a_open_drain_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    fault_wired_line_oe_o |-> !fault_wired_line_o)
    else $error("fault line driven high");

  a_carrier_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(hi_cmd_reg[0]) |-> rise_cnt >= CNT_W'(CARRIER_MIN_CYC))
    else $error("carrier faster than the frequency limit");

  a_sd_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (sd_follow_fault_i && !fault_level_reg) |=> high_side_shutdown_in_o)
    else $error("shutdown output not following fault line");

endmodule : igcfl_host

//--- bench/igcfl_dev_model.sv
// Behavioural gate driver: input gating, shutdown filter and fault line pull
`timescale 1ns/10ps
module igcfl_dev_model #(
  parameter int SD_FILT_CYC  = 83,
  parameter int OCP_HOLD_CYC = 625
) (
  input  wire logic       clk_i,
  input  wire logic [2:0] high_side_cmd_i,
  input  wire logic [2:0] low_side_cmd_i,
  input  wire logic       high_side_shutdown_in_i,
  input  wire logic       fault_wired_line_i,
  input  wire logic       supply_undervoltage_trip_i,
  input  wire logic       overcurrent_trip_i,
  input  wire logic       thermal_trip_i,
  input  wire logic       current_limit_trip_i,
  input  wire logic [2:0] bootstrap_undervoltage_trip_i,
  output logic [2:0]      high_gate_drive_o,
  output logic [2:0]      low_gate_drive_o,
  output logic            current_limit_out_o,
  output logic            fault_pull_transistor_o
);
  logic [2:0] hcmd;
  logic [2:0] lcmd;
  logic [2:0] hcmd_d = 3'h0;
  logic [2:0] hgd    = 3'h0;
  logic [2:0] blk;
  logic       sd_eff;
  int         sd_cnt = 0;
  int         hold   = 0;
  // Undriven or unknown pins read low, as the pull-down would make them
  assign hcmd = {high_side_cmd_i[2] === 1'b1, high_side_cmd_i[1] === 1'b1,
                 high_side_cmd_i[0] === 1'b1};
  assign lcmd = {low_side_cmd_i[2] === 1'b1, low_side_cmd_i[1] === 1'b1,
                 low_side_cmd_i[0] === 1'b1};
  assign sd_eff = (sd_cnt >= SD_FILT_CYC);
  // Bootstrap trip blocks only its own phase and never reaches the fault line
  assign blk = {3{sd_eff | supply_undervoltage_trip_i}} | bootstrap_undervoltage_trip_i;
  // Filter counter, trip hold timer and edge latch of each high side
  always @(posedge clk_i)
  begin
    sd_cnt <= high_side_shutdown_in_i ? ((sd_cnt < SD_FILT_CYC) ? sd_cnt + 1 : sd_cnt) : 0;
    hold <= overcurrent_trip_i ? OCP_HOLD_CYC : ((hold > 0) ? hold - 1 : 0);
    hgd <= ~blk & ((hgd & ~(~hcmd & hcmd_d)) | (hcmd & ~hcmd_d));
    hcmd_d <= hcmd;
  end
  assign high_gate_drive_o = hgd;
  // Low sides follow their commands unless the wired line is low or the supply trips
  assign low_gate_drive_o = lcmd & {3{fault_wired_line_i === 1'b1}}
                          & ~{3{supply_undervoltage_trip_i}};
  assign current_limit_out_o = current_limit_trip_i | overcurrent_trip_i;
  assign fault_pull_transistor_o = supply_undervoltage_trip_i | thermal_trip_i
                                 | overcurrent_trip_i | (hold > 0);
endmodule : igcfl_dev_model

//--- bench/igcfl_host_bench.sv
// Testbench for the gate command controller against the gate driver model
`timescale 1ns/10ps
module igcfl_host_bench;
  import igcfl_pkg::*;
  localparam int PER  = CARRIER_MIN_CYC;
  localparam int HOLD = 625;
  localparam int FILT = 83;
  localparam int LO   = DEAD_CYC + MIN_PULSE_CYC;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             run = 1'b0;
  logic [CNT_W-1:0] du [3] = '{11'h190, 11'h00A, 11'h4D8};
  logic             clr = 1'b0;
  logic             ext = 1'b0;
  logic             fol = 1'b0;
  logic             uv = 1'b0;
  logic             oc = 1'b0;
  logic             th = 1'b0;
  logic             cl = 1'b0;
  logic [2:0]       bt = 3'h0;
  logic             cl_o, fline, fo, oe, sdo, lat, rng, pull, fen;
  logic [2:0]       hc, lc, hg, lg, ph;
  int               hw[3], lw[3], lhw[3], llw[3], gap[3], rt[3], rsp[3];
  int               now, mgap, ovl, ferr, mismatches, checked;
  always #20 clk = ~clk;
  // Open-drain line with pull-up: low when either party pulls
  assign fline = ~(pull | (oe & ~fo));
  igcfl_host #(.PERIOD_CYC(PER)) dut (.clk_i(clk), .sys_rst_i(rst), .run_i(run),
    .duty_u_i(du[0]), .duty_v_i(du[1]), .duty_w_i(du[2]), .clear_i(clr),
    .ext_shutdown_i(ext), .sd_follow_fault_i(fol), .current_limit_out_i(cl_o),
    .fault_wired_line_i(fline), .fault_wired_line_o(fo), .fault_wired_line_oe_o(oe),
    .high_side_cmd_o(hc), .low_side_cmd_o(lc), .high_side_shutdown_in_o(sdo),
    .fault_latched_o(lat), .running_o(rng));
  igcfl_dev_model #(.SD_FILT_CYC(FILT), .OCP_HOLD_CYC(HOLD)) dev (.clk_i(clk),
    .high_side_cmd_i(hc), .low_side_cmd_i(lc), .high_side_shutdown_in_i(sdo),
    .fault_wired_line_i(fline), .supply_undervoltage_trip_i(uv), .overcurrent_trip_i(oc),
    .thermal_trip_i(th), .current_limit_trip_i(cl), .bootstrap_undervoltage_trip_i(bt),
    .high_gate_drive_o(hg), .low_gate_drive_o(lg), .current_limit_out_o(cl_o),
    .fault_pull_transistor_o(pull));
  // Pulse widths, rise spacing, both-low gaps; old values seen before the edge lands
  always @(posedge clk)
  begin
    now++;
    for (int i = 0; i < 3; i++)
    begin
      if (fen && hc[i] && lc[i])
        ovl++;
      if (hc[i] || lc[i])
      begin
        if (fen && gap[i] > 0 && gap[i] < mgap)
          mgap = gap[i];
        gap[i] = 0;
      end
      else
        gap[i]++;
      if (hc[i] === 1'b1 && hw[i] == 0)
      begin
        rsp[i] = now - rt[i];
        rt[i]  = now;
      end
      if (hc[i] !== 1'b1 && hw[i] > 0)
        lhw[i] = hw[i];
      if (lc[i] !== 1'b1 && lw[i] > 0)
        llw[i] = lw[i];
      hw[i] = hc[i] ? hw[i] + 1 : 0;
      lw[i] = lc[i] ? lw[i] + 1 : 0;
    end
    ph = hc;
  end
  // High gate drives should track the commands one edge late, low drives at once, when nothing blocks them
  always @(negedge clk)
    if (fen && (hg !== ph || lg !== (lc & {3{fline}})))
      ferr++;
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // A wait that runs out ends the run at once
  task bound(input int n, input int lim);
    if (n >= lim)
    begin
      mismatches++;
      $display("unexpected wait expected under %0d seen %0d", lim, n);
      print_verdict();
    end
  endtask : bound
  task resume();
    int n;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    fol = 1'b0;
    for (n = 0; n < 20 && rng !== 1'b1; n++)
      @(negedge clk);
    check("rerun", rng, 1);
  endtask : resume
  // A nonzero argument first drops the run request, then resets while the run request is raised again
  task t_reset(input int again);
    if (again != 0)
    begin
      run = 1'b0;
      repeat (3) @(negedge clk);
      check("stop cmds", {hc, lc, rng}, 7'h00);
      run = 1'b1;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
    end
    check("reset cmds", {hc, lc}, 6'h00);
    check("reset pins", {oe, sdo, lat, rng}, 4'h0);
    $display("test reset done");
  endtask : t_reset
  task t_pwm();
    int n, e;
    run = 1'b1;
    for (n = 0; n < 20 && rng !== 1'b1; n++)
      @(negedge clk);
    bound(n, 20);
    repeat (PER * 3) @(negedge clk);
    mgap = PER;
    fen  = 1'b1;
    repeat (PER * 2) @(negedge clk);
    fen = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      e = (du[i] < LO) ? LO : ((du[i] > PER - LO) ? PER - LO : int'(du[i]));
      check("high width", lhw[i], e - DEAD_CYC);
      check("low width", llw[i], PER - e - DEAD_CYC);
      check("rise spacing", rsp[i], PER);
    end
    check("dead time", mgap >= DEAD_CYC, 1);
    check("overlap", ovl, 0);
    check("drive follow", ferr, 0);
    $display("test pwm done");
  endtask : t_pwm
  task t_climit();
    int n;
    cl = 1'b1;
    for (n = 0; n < 10 && sdo !== 1'b1; n++)
      @(negedge clk);
    check("shutdown on", sdo, 1);
    repeat (FILT + 3) @(negedge clk);
    check("high gates", hg, 3'h0);
    check("still running", rng, 1);
    cl = 1'b0;
    repeat (6) @(negedge clk);
    check("shutdown off", sdo, 0);
    // Bootstrap trip on phase U blocks its high side but raises no fault
    bt = 3'h1;
    repeat (3) @(negedge clk);
    check("bootstrap silent", {fline, rng, hg[0]}, 3'h6);
    bt = 3'h0;
    $display("test current limit done");
  endtask : t_climit
  // Overcurrent, thermal and supply trips in turn
  task t_fault(input int k);
    int n;
    fol = 1'b1;
    {oc, th, uv} = 3'h4 >> k;
    for (n = 0; n < FAULT_RESP_CYC && (rng !== 1'b0 || {hc, lc} !== 6'h00); n++)
      @(negedge clk);
    bound(n, FAULT_RESP_CYC);
    check("latched", lat, 1);
    check("line low", fline, 0);
    check("low gates", lg, 3'h0);
    check("follow shutdown", sdo, 1);
    if (k != 0)
      repeat (200) @(negedge clk);
    {oc, th, uv} = 3'h0;
    for (n = 0; n < 1000 && fline !== 1'b1; n++)
      @(negedge clk);
    if (k == 0)
      check("trip hold", n, HOLD);
    bound(n, 1000);
    repeat (10) @(negedge clk);
    check("run refused", rng, 0);
    resume();
    $display("test fault %0d done", k);
  endtask : t_fault
  task t_ext();
    int n;
    ext = 1'b1;
    @(negedge clk);
    ext = 1'b0;
    check("pull on", oe, 1);
    check("open drain data", fo, 0);
    check("low gates", lg, 3'h0);
    for (n = 1; n < 300 && oe === 1'b1; n++)
      @(negedge clk);
    bound(n, 300);
    check("pull length", n >= EXT_SD_HOLD_CYC, 1);
    check("own pull stops", rng, 0);
    repeat (10) @(negedge clk);
    resume();
    $display("test external shutdown done");
  endtask : t_ext
  // Main sequence: reset for eight cycles, then each scenario in turn
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_reset(0);
    t_pwm();
    t_climit();
    for (int k = 0; k < 3; k++)
      t_fault(k);
    t_ext();
    t_reset(1);
    print_verdict();
  end
endmodule : igcfl_host_bench
